// ---- logic/tmb_params.svh ----
// register indices, field positions and reset values of the type b timer
`ifndef TMB_PARAMS_SVH
`define TMB_PARAMS_SVH
`define TMB_IDX_CONTROL_A 6'h00
`define TMB_IDX_CONTROL_B 6'h01
`define TMB_IDX_EVENT_CONTROL 6'h04
`define TMB_IDX_INTEN 6'h05
`define TMB_IDX_FLAGS 6'h06
`define TMB_IDX_STATUS 6'h07
`define TMB_IDX_DBG 6'h08
`define TMB_IDX_TEMP 6'h09
`define TMB_IDX_CNT 6'h0A
`define TMB_IDX_COMPARE_CAPTURE_VALUE 6'h0C
`define TMB_A_ENABLE 0
`define TMB_A_SYNC 4
`define TMB_A_CASCADE 5
`define TMB_A_STBY 6
`define TMB_B_UNSAMPLED_TRIGGER 6
`define TMB_E_CAPTURE_INPUT_ENABLE 0
`define TMB_E_EDGE 4
`define TMB_E_FILTER 6
`define TMB_F_CAPTURE_EVENT 0
`define TMB_F_OVF 1
`define TMB_RST_BYTE 8'h00
`define TMB_RST_WORD 16'h0000
`define TMB_CNT_MAX 16'hFFFF
`define TMB_FILT_LEN 4
`endif

// ---- logic/tmb_pkg.sv ----
// types of the type b timer: clock sources, count modes, state record
package tmb_pkg;
   typedef enum logic [2:0] {
      TMB_CLK_DIV1 = 3'b000,
      TMB_CLK_DIV2 = 3'b001,
      TMB_TIMER_A_CLOCK = 3'b010,
      TMB_CLK_EVT = 3'b111
   } tmb_clk_t;
   typedef enum logic [2:0] {
      TMB_M_INT = 3'b000,
      TMB_M_TIMEOUT = 3'b001,
      TMB_M_CAPTURE_EVENT = 3'b010,
      TMB_M_FRQ = 3'b011,
      TMB_M_PW = 3'b100,
      TMB_M_FRQPW = 3'b101,
      TMB_M_SINGLE = 3'b110,
      TMB_M_PWM8 = 3'b111
   } tmb_mode_t;
   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [7:0] event_control;
      logic [7:0] inten;
      logic [1:0] flags;
      logic [7:0] dbg;
      logic [7:0] temp;
      logic [15:0] cnt;
      logic [15:0] compare_capture_value;
      logic ack;
      logic [31:0] rdata;
      logic div2;
      logic cnt_evt_prev;
      logic [3:0] hist;
      logic lvl;
      logic rise_d;
      logic fall_d;
      logic ss_run;
      logic capture_event_pulse;
      logic ovf_pulse;
   } tmb_state_t;
endpackage

// ---- logic/tmb_core.sv ----
// type b timer: capture events, noise filter, cascade, timer a sync, registers
//
// Overview of operation
// - one capture event loads the live count into each cascaded timer's capture register.
// - upper timer counts lower overflows; its capture register holds the high half.
// - cascade bit set delays the selected capture event by one clock.
// - filter passes a level only when four consecutive samples agree.
// - enabled filter adds exactly four clocks before the capture register updates.
// - filter samples every system clock, ignoring the count prescaler.
// - timer a clock selection advances the counter on timer a's clock.
// - clock field: 0 div1, 1 div2, 2 timer a, 7 count event edge.
// - sync restart with timer a clock selected clears the counter whenever the associated timer a restarts while the timer is enabled and not halted.
// - sync restart without timer a clock follows the first timer a instance.
// - capture and overflow event pulses, one clock wide, mirror flag setting.
// - event clock selection uses rising edges of the sampled count event.
// - capture input enable lets events act; sender registers each event, delaying it one clock.
// - single-shot unsampled trigger takes the raw input edge, skipping filter stages.
// - overflow flag sets when the counter wraps from maximum to zero.
// - enables sit at flag positions: capture bit 0, overflow bit 1.
// - interrupt request holds while a flag and its enable are both set.
// - standby halts unless standby run is set; power-down always halts.
`timescale 1ns/1ps
`include "tmb_params.svh"
module tmb_core
   import tmb_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_capture_event_evt,
   input wire logic i_count_evt,
   input wire logic i_tca_clk_en,
   input wire logic i_tca_restart,
   input wire logic i_tca0_restart,
   input wire logic i_sleep_standby,
   input wire logic i_sleep_powerdown,
   input wire logic i_debug_halt,
   output logic o_capture_event_evt,
   output logic o_ovf_evt,
   output logic o_irq
);
   tmb_state_t s_reg;
   tmb_state_t s_next;
   logic req;
   logic wr;
   logic [5:0] idx;
   logic halt;
   logic active;
   logic tick;
   logic all_eq;
   logic lvl_now;
   logic rise;
   logic fall;
   logic rise_use;
   logic fall_use;
   logic capture_event_set;
   logic ovf_set;
   logic restart;
   logic run_bit;
   logic cnt_wr;
   tmb_clk_t csel;
   tmb_mode_t mode;

   // merge a byte-laned write into a register of two bytes
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction

   // bus request decode, one-cycle answer
   assign req = i_wb_cyc & i_wb_stb & ~s_reg.ack;
   assign wr = req & i_wb_we;
   assign idx = i_wb_adr[7:2];
   assign csel = tmb_clk_t'(s_reg.ctrl_a[3:1]);
   assign mode = tmb_mode_t'(s_reg.ctrl_b[2:0]);
   assign cnt_wr = wr && idx == `TMB_IDX_CNT;

   // sleep and debug halting
   assign halt = i_sleep_powerdown
      | (i_sleep_standby & ~s_reg.ctrl_a[`TMB_A_STBY])
      | (i_debug_halt & ~s_reg.dbg[0]);
   assign active = s_reg.ctrl_a[`TMB_A_ENABLE] & ~halt;

   // count clock selection
   always_comb begin
      case (csel)
         TMB_CLK_DIV1: tick = active;
         TMB_CLK_DIV2: tick = active & s_reg.div2;
         TMB_TIMER_A_CLOCK: tick = active & i_tca_clk_en;
         TMB_CLK_EVT: tick = active & i_count_evt & ~s_reg.cnt_evt_prev;
         default: tick = 1'b0;
      endcase
   end

   // noise filter and edge detection on the capture input
   assign all_eq = (&s_reg.hist) | ~(|s_reg.hist);
   always_comb begin
      if (mode == TMB_M_SINGLE && s_reg.ctrl_b[`TMB_B_UNSAMPLED_TRIGGER]) begin
         lvl_now = i_capture_event_evt;
      end else if (s_reg.event_control[`TMB_E_FILTER]) begin
         lvl_now = all_eq ? s_reg.hist[3] : s_reg.lvl;
      end else begin
         lvl_now = i_capture_event_evt;
      end
   end
   assign rise = lvl_now & ~s_reg.lvl & s_reg.event_control[`TMB_E_CAPTURE_INPUT_ENABLE];
   assign fall = ~lvl_now & s_reg.lvl & s_reg.event_control[`TMB_E_CAPTURE_INPUT_ENABLE];
   assign rise_use = s_reg.ctrl_a[`TMB_A_CASCADE] ? s_reg.rise_d : rise;
   assign fall_use = s_reg.ctrl_a[`TMB_A_CASCADE] ? s_reg.fall_d : fall;

   // synchronised restart source
   assign restart = active & s_reg.ctrl_a[`TMB_A_SYNC]
      & (csel == TMB_TIMER_A_CLOCK ? i_tca_restart : i_tca0_restart);

   assign run_bit = active & (mode != TMB_M_SINGLE | s_reg.ss_run);

   // next state of the whole block
   always_comb begin
      logic cap_edge;
      logic clr_edge;
      logic cap;
      logic clr;
      logic wrap;
      s_next = s_reg;
      cap_edge = s_reg.event_control[`TMB_E_EDGE] ? fall_use : rise_use;
      clr_edge = s_reg.event_control[`TMB_E_EDGE] ? rise_use : fall_use;
      cap = 1'b0;
      clr = 1'b0;
      wrap = 1'b0;
      capture_event_set = 1'b0;
      ovf_set = 1'b0;
      s_next.ack = req;
      s_next.cnt_evt_prev = i_count_evt;
      s_next.hist = {s_reg.hist[2:0], i_capture_event_evt};
      s_next.lvl = lvl_now;
      s_next.rise_d = rise;
      s_next.fall_d = fall;
      s_next.div2 = active ? ~s_reg.div2 : 1'b0;
      // event actions per count mode
      if (active) begin
         case (mode)
            TMB_M_INT: begin
               if (tick && s_reg.cnt == s_reg.compare_capture_value) begin
                  capture_event_set = 1'b1;
                  clr = 1'b1;
               end
            end
            TMB_M_CAPTURE_EVENT: cap = cap_edge;
            TMB_M_FRQ: begin
               cap = cap_edge;
               clr = cap_edge;
            end
            TMB_M_PW: begin
               cap = cap_edge;
               clr = clr_edge;
            end
            TMB_M_SINGLE: begin
               if (!s_reg.ss_run && (rise || (s_reg.event_control[`TMB_E_EDGE] && fall))) begin
                  s_next.ss_run = 1'b1;
                  clr = 1'b1;
               end else if (s_reg.ss_run && tick && s_reg.cnt == s_reg.compare_capture_value) begin
                  s_next.ss_run = 1'b0;
                  capture_event_set = 1'b1;
               end
            end
            default: cap = 1'b0;
         endcase
      end
      if (cap) begin
         s_next.compare_capture_value = s_reg.cnt;
         capture_event_set = 1'b1;
      end
      // counter update, bus write and restart take priority
      if (tick && (mode != TMB_M_SINGLE || s_reg.ss_run)) begin
         wrap = s_reg.cnt == `TMB_CNT_MAX;
         s_next.cnt = s_reg.cnt + 16'h0001;
      end
      ovf_set = wrap;
      if (clr || restart) begin
         s_next.cnt = `TMB_RST_WORD;
      end
      s_next.capture_event_pulse = capture_event_set;
      s_next.ovf_pulse = ovf_set;
      // register writes
      if (wr) begin
         case (idx)
            `TMB_IDX_CONTROL_A: if (i_wb_sel[0]) s_next.ctrl_a = i_wb_dat[7:0];
            `TMB_IDX_CONTROL_B: if (i_wb_sel[0]) s_next.ctrl_b = i_wb_dat[7:0];
            `TMB_IDX_EVENT_CONTROL: if (i_wb_sel[0]) s_next.event_control = i_wb_dat[7:0];
            `TMB_IDX_INTEN: if (i_wb_sel[0]) s_next.inten = i_wb_dat[7:0];
            `TMB_IDX_FLAGS: if (i_wb_sel[0]) s_next.flags = s_reg.flags & ~i_wb_dat[1:0];
            `TMB_IDX_DBG: if (i_wb_sel[0]) s_next.dbg = i_wb_dat[7:0];
            `TMB_IDX_TEMP: if (i_wb_sel[0]) s_next.temp = i_wb_dat[7:0];
            `TMB_IDX_CNT: s_next.cnt = merge(s_reg.cnt, i_wb_dat, i_wb_sel);
            `TMB_IDX_COMPARE_CAPTURE_VALUE: s_next.compare_capture_value = merge(s_reg.compare_capture_value, i_wb_dat, i_wb_sel);
            default: s_next.ack = req;
         endcase
      end
      // hardware set wins over software clear
      if (capture_event_set) s_next.flags[`TMB_F_CAPTURE_EVENT] = 1'b1;
      if (ovf_set) s_next.flags[`TMB_F_OVF] = 1'b1;
      // read data
      s_next.rdata = 32'h0000_0000;
      case (idx)
         `TMB_IDX_CONTROL_A: s_next.rdata[7:0] = s_reg.ctrl_a;
         `TMB_IDX_CONTROL_B: s_next.rdata[7:0] = s_reg.ctrl_b;
         `TMB_IDX_EVENT_CONTROL: s_next.rdata[7:0] = s_reg.event_control;
         `TMB_IDX_INTEN: s_next.rdata[7:0] = s_reg.inten;
         `TMB_IDX_FLAGS: s_next.rdata[1:0] = s_reg.flags;
         `TMB_IDX_STATUS: s_next.rdata[0] = run_bit;
         `TMB_IDX_DBG: s_next.rdata[7:0] = s_reg.dbg;
         `TMB_IDX_TEMP: s_next.rdata[7:0] = s_reg.temp;
         `TMB_IDX_CNT: s_next.rdata[15:0] = s_reg.cnt;
         `TMB_IDX_COMPARE_CAPTURE_VALUE: s_next.rdata[15:0] = s_reg.compare_capture_value;
         default: s_next.rdata = 32'h0000_0000;
      endcase
      if (!req) s_next.rdata = 32'h0000_0000;
   end

   // state register
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs
   assign o_wb_ack = s_reg.ack;
   assign o_wb_dat = s_reg.rdata;
   assign o_capture_event_evt = s_reg.capture_event_pulse;
   assign o_ovf_evt = s_reg.ovf_pulse;
   assign o_irq = |(s_reg.flags & s_reg.inten[1:0]);

   // checks beside the logic
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   a_ovf_flag_set: assert property (ovf_set |=> s_reg.flags[1] && o_ovf_evt)
      else $error("overflow did not set flag and event");
   a_capture_event_evt_flag: assert property (o_capture_event_evt |-> s_reg.flags[0])
      else $error("capture event without flag");
   a_irq_holds: assert property (s_reg.flags[0] && s_reg.inten[0] |-> o_irq)
      else $error("irq low with enabled capture flag");
   a_irq_gated: assert property (!s_reg.inten[0] && !s_reg.inten[1] |-> !o_irq)
      else $error("irq without enable");
   a_cascade_delay: assert property (s_reg.ctrl_a[5] && rise |=> rise_use)
      else $error("cascade capture not delayed");
   a_filter_hold: assert property (s_reg.event_control[6] && mode != TMB_M_SINGLE && !all_eq
      |-> lvl_now == s_reg.lvl)
      else $error("filter passed unstable level");
   a_div2_rate: assert property (csel == TMB_CLK_DIV2 && tick |=> !tick)
      else $error("div2 ticked twice in a row");
   a_powerdown_halt: assert property (i_sleep_powerdown |-> !tick && !run_bit)
      else $error("counted in power-down");
   a_sync_restart: assert property (restart && !cnt_wr |=> s_reg.cnt == 16'h0000)
      else $error("sync restart did not clear counter");
   a_run_stopped: assert property (!s_reg.ctrl_a[0] |-> !run_bit)
      else $error("run bit set while disabled");

   // every capture flag condition is echoed on the event pin next cycle
   a_capture_event_evt_next: assert property (capture_event_set |=> o_capture_event_evt)
      else $error("capture event pulse missing");
   // no capture event pulse without a flag condition before it
   a_capture_event_evt_cause: assert property (o_capture_event_evt |-> $past(capture_event_set))
      else $error("capture event pulse without cause");
   // no overflow event pulse without a wrap before it
   a_ovf_evt_cause: assert property (o_ovf_evt |-> $past(ovf_set))
      else $error("overflow event pulse without wrap");
   // overflow only on a count tick from the top value
   a_ovf_at_max: assert property (ovf_set |-> tick && s_reg.cnt == `TMB_CNT_MAX)
      else $error("overflow away from maximum");
   // a plain wrap in capture mode lands on zero
   a_wrap_zero: assert property (ovf_set && mode == TMB_M_CAPTURE_EVENT && !restart && !cnt_wr
      |=> s_reg.cnt == 16'h0000)
      else $error("counter did not wrap to zero");
   // enabled overflow flag keeps the request up
   a_irq_ovf: assert property (s_reg.flags[1] && s_reg.inten[1] |-> o_irq)
      else $error("irq low with enabled overflow flag");
   // request only from a flag whose own enable is set
   a_irq_cause: assert property (o_irq
      |-> s_reg.flags[0] && s_reg.inten[0] || s_reg.flags[1] && s_reg.inten[1])
      else $error("irq from a disabled source");
   // standby without standby run stops counting
   a_standby_halt: assert property (i_sleep_standby && !s_reg.ctrl_a[`TMB_A_STBY]
      |-> !tick && !run_bit)
      else $error("counted in standby");
   // a halted or disabled timer never ticks
   a_idle_no_tick: assert property (!active |-> !tick)
      else $error("tick while not active");
   // undivided source ticks every active cycle
   a_div1_rate: assert property (csel == TMB_CLK_DIV1 && active |-> tick)
      else $error("div1 missed a tick");
   // timer a source follows timer a's count enable exactly
   a_tca_clock: assert property (csel == TMB_TIMER_A_CLOCK |-> tick == (active && i_tca_clk_en))
      else $error("tick not on timer a clock");
   // event source ticks only on a rising count event
   a_evt_clock: assert property (csel == TMB_CLK_EVT && tick
      |-> i_count_evt && !s_reg.cnt_evt_prev)
      else $error("event tick without rising edge");
   // reserved clock codes never count
   a_reserved_idle: assert property (s_reg.ctrl_a[3:1] inside {[3'h3:3'h6]} |-> !tick)
      else $error("tick on reserved clock code");
   // idle single shot reports stopped
   a_run_single: assert property (mode == TMB_M_SINGLE && !s_reg.ss_run |-> !run_bit)
      else $error("run bit set in idle single shot");
   // status read returns the live run bit
   a_status_read: assert property (req && !i_wb_we && idx == `TMB_IDX_STATUS
      |=> o_wb_dat[0] == $past(run_bit))
      else $error("status read wrong run bit");
   // a capture edge copies the live count
   a_capture_copy: assert property (active && mode == TMB_M_CAPTURE_EVENT
      && !s_reg.event_control[`TMB_E_EDGE] && rise_use && !(wr && idx == `TMB_IDX_COMPARE_CAPTURE_VALUE)
      |=> s_reg.compare_capture_value == $past(s_reg.cnt))
      else $error("capture did not copy the count");
   // a set flag stays until software writes the flag register
   a_flag_sticky: assert property (s_reg.flags[0] && !(wr && idx == `TMB_IDX_FLAGS)
      |=> s_reg.flags[0])
      else $error("capture flag lost without clear");
   // writing one clears the capture flag when no new event sets it
   a_flag_clear: assert property (wr && idx == `TMB_IDX_FLAGS && i_wb_sel[0] && i_wb_dat[0]
      && !capture_event_set |=> !s_reg.flags[0])
      else $error("capture flag not cleared");
   // restart from the first timer a when another source is selected
   a_tca0_restart: assert property (active && s_reg.ctrl_a[`TMB_A_SYNC] && csel != TMB_TIMER_A_CLOCK
      && i_tca0_restart && !cnt_wr |=> s_reg.cnt == 16'h0000)
      else $error("first timer a restart missed");
   // filtered level changes only after four equal samples
   a_filter_four: assert property (s_reg.event_control[`TMB_E_FILTER]
      && !(mode == TMB_M_SINGLE && s_reg.ctrl_b[`TMB_B_UNSAMPLED_TRIGGER])
      && lvl_now != s_reg.lvl |-> all_eq)
      else $error("filter changed level on unequal samples");
   // unsampled trigger takes the raw input
   a_unsampled_trigger_raw: assert property (mode == TMB_M_SINGLE && s_reg.ctrl_b[`TMB_B_UNSAMPLED_TRIGGER]
      |-> lvl_now == i_capture_event_evt)
      else $error("unsampled trigger not raw");
   // without the filter the input reaches the edge detector at once
   a_nofilter_raw: assert property (!s_reg.event_control[`TMB_E_FILTER] |-> lvl_now == i_capture_event_evt)
      else $error("latency added without filter");
   // capture input disabled means no edges
   a_capture_input_enable_gate: assert property (!s_reg.event_control[`TMB_E_CAPTURE_INPUT_ENABLE] |-> !rise && !fall)
      else $error("edge seen with capture input off");
   // no cascade, no delay
   a_cascade_plain: assert property (!s_reg.ctrl_a[`TMB_A_CASCADE]
      |-> rise_use == rise && fall_use == fall)
      else $error("capture delayed without cascade");
   // the filter history shifts every system clock
   a_hist_sample: assert property (1'b1 |=> s_reg.hist[0] == $past(i_capture_event_evt))
      else $error("filter missed a sample");

   // capture in input capture mode, for the cover below
   logic cap_edge_seen;
   assign cap_edge_seen = capture_event_set && mode == TMB_M_CAPTURE_EVENT;

   c_capture: cover property (cap_edge_seen);
   c_overflow: cover property (ovf_set ##1 o_ovf_evt);
   c_filtered: cover property (s_reg.event_control[6] && capture_event_set);
   c_single: cover property (s_reg.ss_run ##1 !s_reg.ss_run);
   c_cascade: cover property (s_reg.ctrl_a[5] && rise_use);
endmodule // tmb_core

// ---- test/tmb_partner.sv ----
// event network and timer a stand-in feeding the type b timer's event inputs
`timescale 1ns/1ps
module tmb_partner (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_capture_event_req,
   output logic o_capture_event_evt,
   output logic o_count_evt,
   output logic o_tca_clk_en,
   output logic o_tca_restart,
   output logic o_tca0_restart
);
   logic [7:0] tick_reg;
   // registered event copy, so every event lasts whole clocks
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         tick_reg <= 8'h00;
         o_capture_event_evt <= 1'b0;
      end else begin
         tick_reg <= tick_reg + 8'h01;
         o_capture_event_evt <= i_capture_event_req;
      end
   end
   // timer a prescale pulse every third clock, back to back at the 255-to-0 wrap, restarts, slow count event
   assign o_tca_clk_en = (tick_reg % 8'h03) == 8'h00;
   assign o_tca_restart = tick_reg[5:0] == 6'h3F;
   assign o_tca0_restart = tick_reg == 8'hFF;
   assign o_count_evt = tick_reg[2];
endmodule // tmb_partner

// ---- test/tmb_core_tb.sv ----
// self-checking bench of the type b timer with a behavioural count model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module tmb_core_tb;
   import tmb_pkg::*;
   logic clk, rst, cyc, stb, we, capture_event_req, stby, pd, halt, ce, cnt_e, tca_en, tr, tr0, ce_d;
   logic [7:0] adr;
   logic [31:0] dat, q, o_wb_dat;
   logic o_wb_ack, o_capture_event_evt, o_ovf_evt, o_irq;
   logic [15:0] row, r0, e;
   int n_fail = 0, checked = 0, seed = 32'h3d08, n, pc, c0, t0, x0;
   int n_cyc = 0, n_tca = 0, n_rise = 0, n_capture_event = 0, n_ovf = 0, s_cyc, s_tca, s_rise;
   logic [15:0] rows[10] = '{16'h0101, 16'h0302, 16'h0503, 16'h0F04, 16'h0000,
      16'h0180, 16'h4181, 16'h4140, 16'h0120, 16'h0131};
   logic [15:0] cap[$];
   logic [7:0] offs[10] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24,
      8'h28, 8'h30};
   tmb_core tmb_core_inst (.i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat(o_wb_dat),
      .o_wb_ack(o_wb_ack), .i_capture_event_evt(ce), .i_count_evt(cnt_e), .i_tca_clk_en(tca_en),
      .i_tca_restart(tr), .i_tca0_restart(tr0), .i_sleep_standby(stby),
      .i_sleep_powerdown(pd), .i_debug_halt(halt), .o_capture_event_evt(o_capture_event_evt),
      .o_ovf_evt(o_ovf_evt), .o_irq(o_irq));
   tmb_partner tmb_partner_inst (.i_clk_sys(clk), .i_rst(rst), .i_capture_event_req(capture_event_req),
      .o_capture_event_evt(ce), .o_count_evt(cnt_e), .o_tca_clk_en(tca_en), .o_tca_restart(tr),
      .o_tca0_restart(tr0));
   // clock, reset and idle inputs
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst, cyc, stb, we, capture_event_req, stby, pd, halt, adr, dat} = {1'b1, 47'h0};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
   end
   // pulse and edge tallies seen on the design's pins
   always @(posedge clk) begin
      n_cyc <= n_cyc + 1;
      n_tca <= n_tca + tca_en;
      n_rise <= n_rise + (cnt_e & !ce_d);
      ce_d <= cnt_e;
      n_capture_event <= n_capture_event + o_capture_event_evt;
      n_ovf <= n_ovf + o_ovf_evt;
   end
   // one classic wishbone cycle; tallies are snapshot before the taking edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      we <= w;
      adr <= a;
      dat <= d;
      cyc <= 1'b1;
      stb <= 1'b1;
      @(negedge clk);
      {s_cyc, s_tca, s_rise} = {n_cyc, n_tca, n_rise};
      while (o_wb_ack !== 1'b1 && k < 50) begin
         @(negedge clk);
         k++;
      end
      if (k >= 50) n_fail++;
      q = o_wb_dat;
      @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task give_verdict();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
   initial begin
      @(negedge rst);
      // reset values, read/write, unmapped and read-only places
      foreach (rows[i]) begin
         bus(1'b0, offs[i], 32'h0);
         `CHK("reset_value", 32'h0, q)
      end
      e = $random(seed);
      bus(1'b1, 8'h30, {16'h0, e});
      bus(1'b1, 8'h24, {24'h0, e[15:8]});
      bus(1'b1, 8'h08, 32'hFF);
      bus(1'b1, 8'h1C, 32'hFF);
      bus(1'b0, 8'h30, 32'h0);
      `CHK("compare_capture_value_rw", e, q[15:0])
      bus(1'b0, 8'h24, 32'h0);
      `CHK("latch_rw", e[15:8], q[7:0])
      bus(1'b0, 8'h08, 32'h0);
      `CHK("unmapped", 32'h0, q)
      bus(1'b0, 8'h1C, 32'h0);
      `CHK("status_ro", 32'h0, q)
      $display("test registers done");
      // clock sources, sleep and debug halting against the tally model
      bus(1'b1, 8'h04, 32'h01);
      foreach (rows[i]) begin
         row = rows[i];
         bus(1'b1, 8'h20, {31'h0, row[4]});
         bus(1'b1, 8'h00, {24'h0, row[15:8]});
         {stby, pd, halt} <= row[7:5];
         bus(1'b0, 8'h28, 32'h0);
         {r0, c0, t0, x0} = {q[15:0], s_cyc, s_tca, s_rise};
         repeat (2 * ($unsigned($random(seed)) % 8) + 9) @(posedge clk);
         bus(1'b0, 8'h28, 32'h0);
         case (row[2:0])
            3'h1: e = s_cyc - c0;
            3'h2: e = (s_cyc - c0) / 2;
            3'h3: e = s_tca - t0;
            3'h4: e = s_rise - x0;
            default: e = 16'h0;
         endcase
         `CHK("count_delta", e, q[15:0] - r0)
         if (!(row[7] & !row[14] | row[6] | row[5] & !row[4])) begin
            bus(1'b0, 8'h1C, 32'h0);
            `CHK("run_status", row[8], q[0])
         end
      end
      {stby, pd, halt} <= 3'h0;
      $display("test clocking done");
      // capture plain, filtered and cascaded, each with its own enables
      bus(1'b1, 8'h04, 32'h02);
      for (int v = 0; v < 3; v++) begin
         bus(1'b1, 8'h00, (v == 2) ? 32'h21 : 32'h01);
         bus(1'b1, 8'h10, (v == 1) ? 32'h41 : 32'h01);
         bus(1'b1, 8'h14, v + 1);
         bus(1'b1, 8'h18, 32'h03);
         pc = n_capture_event;
         bus(1'b1, 8'h28, 32'h0);
         capture_event_req <= 1'b1;
         n = 0;
         do bus(1'b0, 8'h18, 32'h0); while (q[0] !== 1'b1 && n++ < 20);
         `CHK("capture_event_flag", 1'b1, q[0])
         bus(1'b0, 8'h30, 32'h0);
         cap.push_back(q[15:0]);
         `CHK("irq_capture_event", v != 1, o_irq)
         capture_event_req <= 1'b0;
         repeat (8) @(posedge clk);
         `CHK("capture_event_pulses", 1, n_capture_event - pc)
         bus(1'b1, 8'h18, 32'h01);
         bus(1'b0, 8'h18, 32'h0);
         `CHK("flag_clear", 2'h0, q[1:0])
         `CHK("irq_clear", 1'b0, o_irq)
      end
      `CHK("filter_delay", 16'h4, cap[1] - cap[0])
      `CHK("cascade_delay", 16'h1, cap[2] - cap[0])
      $display("test capture done");
      // overflow from the top of the count
      bus(1'b1, 8'h00, 32'h01);
      bus(1'b1, 8'h10, 32'h00);
      bus(1'b1, 8'h14, 32'h02);
      pc = n_ovf;
      bus(1'b1, 8'h28, 32'hFFF0);
      n = 0;
      do bus(1'b0, 8'h18, 32'h0); while (q[1] !== 1'b1 && n++ < 40);
      `CHK("ovf_pulses", 1, n_ovf - pc)
      `CHK("irq_ovf", 1'b1, o_irq)
      bus(1'b0, 8'h28, 32'h0);
      `CHK("wrapped", 8'h00, q[15:8])
      $display("test overflow done");
      // restart with the associated and with the first timer a
      for (int v = 0; v < 2; v++) begin
         bus(1'b1, 8'h00, v ? 32'h11 : 32'h15);
         repeat (300) @(posedge clk);
         repeat (8) begin
            repeat ($unsigned($random(seed)) % 64) @(posedge clk);
            bus(1'b0, 8'h28, 32'h0);
            `CHK("sync_bound", 1'b1, q[15:0] <= (v ? 16'h0101 : 16'h0017))
         end
      end
      $display("test restart done");
      give_verdict();
   end
endmodule // tmb_core_tb
